/* File: rtl/tec_seq_pkg.sv */
package tec_seq_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS  = 10;
	localparam int CYC_PER_MS     = 1000000 / CLK_PERIOD_NS;
	localparam int SD_DELAY_MS    = 30;
	localparam int HICCUP_OFF_MS  = 15;
	localparam int DETECT_MS      = 1;
	localparam int DISCHARGE_US   = 500;
	localparam int SS_TOTAL_MS    = 120;
	localparam int SS_SPLIT_NUM   = 8;
	localparam int SS_SPLIT_DEN   = 19;
	localparam int SD_DELAY_CYC   = SD_DELAY_MS * CYC_PER_MS;
	localparam int HICCUP_OFF_CYC = HICCUP_OFF_MS * CYC_PER_MS;
	localparam int DETECT_CYC     = DETECT_MS * CYC_PER_MS;
	localparam int DISCHARGE_CYC  = DISCHARGE_US * 1000 / CLK_PERIOD_NS;
	localparam int SS_SPLIT_CYC   = SS_TOTAL_MS * CYC_PER_MS * SS_SPLIT_NUM / SS_SPLIT_DEN;
	localparam int TMR_W          = 24;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_HEAT_VOLTAGE_LIMIT_FLAG = 8'h03;
	localparam logic [7:0] REG_COOL_VOLTAGE_LIMIT_FLAG = 8'h04;
	localparam logic [7:0] REG_ADDR      = 8'h06;
	localparam logic [7:0] REG_STATUS    = 8'h09;
	localparam logic [7:0] REG_ID        = 8'h0A;
	localparam int CTRL_MON_BIT  = 7;
	localparam int CTRL_SS_LSB   = 2;
	localparam int CTRL_REL_BIT  = 1;
	localparam int CTRL_EN_BIT   = 0;
	localparam logic [7:0] CTRL_RESET      = 8'h81;
	localparam logic [5:0] VOLTAGE_LIMIT_FLAG_CODE_RESET = 6'h1C;
	localparam logic [5:0] VOLTAGE_LIMIT_FLAG_CODE_MAX   = 6'h37;
	localparam logic [1:0] DIR_BOUNDARY    = 2'h0;
	localparam logic [1:0] DIR_COOL        = 2'h1;
	localparam logic [1:0] DIR_HEAT        = 2'h2;
	localparam logic [6:0] ADDR_STRAP_LOW  = 7'h21;
	localparam logic [6:0] ADDR_STRAP_HIGH = 7'h60;
	localparam logic [3:0] MAKER_CODE      = 4'hA; // Arbitrary value
	localparam logic [3:0] REVISION_CODE   = 4'h3; // Arbitrary value

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		SEQ_OFF       = 3'h0,
		SEQ_DISCHARGE = 3'h1,
		SEQ_RAMP_JNT  = 3'h2,
		SEQ_RAMP_SPL  = 3'h3,
		SEQ_RUN       = 3'h4,
		SEQ_HIC_OFF   = 3'h5,
		SEQ_HIC_DET   = 3'h6
	} seq_state_t;

	typedef enum logic [2:0] {
		LNK_IDLE  = 3'h0,
		LNK_ADDR  = 3'h1,
		LNK_PTR   = 3'h2,
		LNK_WDATA = 3'h3,
		LNK_RDATA = 3'h4
	} link_phase_t;

endpackage : tec_seq_pkg

/* File: rtl/pin_sync.sv */
`timescale 1ns/10ps
// ****************************************
// Two-stage synchroniser
// ****************************************
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_ff;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_ff <= '0;
			q       <= '0;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule : pin_sync

/* File: rtl/tec_seq_status.sv */
`timescale 1ns/10ps
module tec_seq_status #(
	parameter int SD_DELAY_CYC   = tec_seq_pkg::SD_DELAY_CYC,
	parameter int HICCUP_OFF_CYC = tec_seq_pkg::HICCUP_OFF_CYC,
	parameter int DETECT_CYC     = tec_seq_pkg::DETECT_CYC,
	parameter int DISCHARGE_CYC  = tec_seq_pkg::DISCHARGE_CYC,
	parameter int SS_SPLIT_CYC   = tec_seq_pkg::SS_SPLIT_CYC
) (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       scl,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       supply_ok,
	input  wire logic       enable_pin,
	input  wire logic       shutdown_n_pin,
	input  wire logic       addr_strap,
	input  wire logic       outputs_low,
	input  wire logic       mid_level_reached,
	input  wire logic       voltage_limit_flag_reached,
	input  wire logic       current_limit_flag_reached,
	input  wire logic       overtemp_in,
	input  wire logic       overtemp_warn_in,
	input  wire logic       secondary_ov,
	input  wire logic       hard_fault,
	input  wire logic       heating_det,
	input  wire logic       cooling_det,
	output logic            legs_enable,
	output logic            discharge_step,
	output logic            joint_ramp,
	output logic            split_ramp,
	output logic            detect_regulate,
	output logic            regulate_at_limit,
	output logic            power_stage_active,
	output logic            monitor_select,
	output logic [5:0]      heat_voltage_limit_code,
	output logic [5:0]      cool_voltage_limit_code
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [13:0] pins_s;
	logic        supply_s, enable_s, sdn_s, strap_s, low_s, mid_s, voltage_limit_flag_s;
	logic        current_limit_flag_s, ot_s, otw_s, sov_s, fault_s, heat_s, cool_s;

	pin_sync #(.WIDTH(14)) u_pin_sync (
		.clk    (clk),
		.resetn (resetn),
		.d      ({supply_ok, enable_pin, shutdown_n_pin, addr_strap, outputs_low, mid_level_reached,
		          voltage_limit_flag_reached, current_limit_flag_reached, overtemp_in, overtemp_warn_in, secondary_ov, hard_fault,
		          heating_det, cooling_det}),
		.q      (pins_s)
	);

	assign {supply_s, enable_s, sdn_s, strap_s, low_s, mid_s, voltage_limit_flag_s,
	        current_limit_flag_s, ot_s, otw_s, sov_s, fault_s, heat_s, cool_s} = pins_s;

	// ****************************************
	// Link side: start/stop detection
	// ****************************************
	logic start_tgl_ff;
	logic open_tgl_ff;
	logic stop_tgl_ff;

	// Start: data falls while clock high; frame opens only when idle
	always_ff @(negedge sda_in or negedge resetn) begin
		if (!resetn) begin
			start_tgl_ff <= 1'b0;
			open_tgl_ff  <= 1'b0;
		end else if (scl) begin
			start_tgl_ff <= ~start_tgl_ff;
			if (open_tgl_ff == stop_tgl_ff) begin
				open_tgl_ff <= ~open_tgl_ff; // Repeated start keeps frame open
			end
		end
	end

	// Stop: data rises while clock high; closes an open frame
	always_ff @(posedge sda_in or negedge resetn) begin
		if (!resetn) begin
			stop_tgl_ff <= 1'b0;
		end else if (scl && (open_tgl_ff != stop_tgl_ff)) begin
			stop_tgl_ff <= ~stop_tgl_ff;
		end
	end

	// ****************************************
	// Link side: byte engine on bus clock
	// ****************************************
	tec_seq_pkg::link_phase_t phase_ff;
	logic       start_seen_ff;
	logic [3:0] bit_cnt_ff;
	logic [6:0] shift_ff;
	logic       ack_ff;
	logic       rw_ff;
	logic [7:0] ptr_ff;
	logic [7:0] tx_ff;
	logic [7:0] wr_addr_ff;
	logic [7:0] wr_data_ff;
	logic       wr_tgl_ff;
	logic [7:0] byte_in;
	logic [7:0] last_byte_ff;
	logic [6:0] snap_addr_ff;
	logic [7:0] snap_ctrl_ff;
	logic [7:0] snap_status_ff;
	logic [5:0] snap_heat_ff;
	logic [5:0] snap_cool_ff;

	assign byte_in = {shift_ff, sda_in};

	// Register read decode from the frozen snapshot
	function automatic logic [7:0] reg_read(input logic [7:0] a);
		logic [7:0] r;
		r = 8'h00;
		unique case (a)
			tec_seq_pkg::REG_CTRL:      r = snap_ctrl_ff;
			tec_seq_pkg::REG_HEAT_VOLTAGE_LIMIT_FLAG: r = {2'h0, snap_heat_ff};
			tec_seq_pkg::REG_COOL_VOLTAGE_LIMIT_FLAG: r = {2'h0, snap_cool_ff};
			tec_seq_pkg::REG_ADDR:      r = {snap_addr_ff, 1'b0};
			tec_seq_pkg::REG_STATUS:    r = snap_status_ff;
			tec_seq_pkg::REG_ID:        r = {tec_seq_pkg::MAKER_CODE, tec_seq_pkg::REVISION_CODE};
			default:                    r = 8'h00;
		endcase
		return r;
	endfunction : reg_read

	// Bit counting, address match, pointer and writes
	always_ff @(posedge scl or negedge resetn) begin
		if (!resetn) begin
			phase_ff      <= tec_seq_pkg::LNK_IDLE;
			start_seen_ff <= 1'b0;
			bit_cnt_ff    <= 4'h0;
			shift_ff      <= 7'h00;
			ack_ff        <= 1'b0;
			rw_ff         <= 1'b0;
			ptr_ff        <= 8'h00;
			tx_ff         <= 8'h00;
			wr_addr_ff    <= 8'h00;
			wr_data_ff    <= 8'h00;
			wr_tgl_ff     <= 1'b0;
		end else if (start_tgl_ff != start_seen_ff) begin
			start_seen_ff <= start_tgl_ff;
			phase_ff      <= tec_seq_pkg::LNK_ADDR;
			shift_ff      <= {6'h00, sda_in};
			bit_cnt_ff    <= 4'h1;
			ack_ff        <= 1'b0;
		end else if (phase_ff != tec_seq_pkg::LNK_IDLE) begin
			if (bit_cnt_ff < 4'h8) begin
				shift_ff   <= byte_in[6:0];
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
				if (bit_cnt_ff == 4'h7) begin
					unique case (phase_ff)
						tec_seq_pkg::LNK_ADDR: begin
							ack_ff <= (byte_in[7:1] == snap_addr_ff);
							rw_ff  <= byte_in[0];
						end
						tec_seq_pkg::LNK_RDATA: ack_ff <= 1'b0;
						default:                ack_ff <= 1'b1;
					endcase
				end
			end else begin
				bit_cnt_ff <= 4'h0;
				unique case (phase_ff)
					tec_seq_pkg::LNK_ADDR: begin
						if (!ack_ff) begin
							phase_ff <= tec_seq_pkg::LNK_IDLE;
						end else if (rw_ff) begin
							phase_ff <= tec_seq_pkg::LNK_RDATA;
							tx_ff    <= reg_read(ptr_ff);
						end else begin
							phase_ff <= tec_seq_pkg::LNK_PTR;
						end
					end
					tec_seq_pkg::LNK_PTR: begin
						ptr_ff   <= last_byte_ff;
						phase_ff <= tec_seq_pkg::LNK_WDATA;
					end
					tec_seq_pkg::LNK_WDATA: begin
						wr_addr_ff <= ptr_ff;
						wr_data_ff <= last_byte_ff;
						wr_tgl_ff  <= ~wr_tgl_ff;
						ptr_ff     <= ptr_ff + 8'h01;
					end
					tec_seq_pkg::LNK_RDATA: begin
						if (sda_in) begin
							phase_ff <= tec_seq_pkg::LNK_IDLE;
						end else begin
							ptr_ff <= ptr_ff + 8'h01;
							tx_ff  <= reg_read(ptr_ff + 8'h01);
						end
					end
					default: phase_ff <= tec_seq_pkg::LNK_IDLE;
				endcase
			end
		end
	end

	// Byte as completed on the eighth bit
	always_ff @(posedge scl or negedge resetn) begin
		if (!resetn) begin
			last_byte_ff <= 8'h00;
		end else if (bit_cnt_ff == 4'h7) begin
			last_byte_ff <= byte_in;
		end
	end

	// Open-drain drive on falling bus clock
	always_ff @(negedge scl or negedge resetn) begin
		if (!resetn) begin
			sda_oe <= 1'b0;
		end else if (start_tgl_ff != start_seen_ff) begin
			sda_oe <= 1'b0;
		end else if (bit_cnt_ff == 4'h8) begin
			sda_oe <= ack_ff;
		end else if (phase_ff == tec_seq_pkg::LNK_RDATA) begin
			sda_oe <= ~tx_ff[3'(4'h7 - bit_cnt_ff)];
		end else begin
			sda_oe <= 1'b0;
		end
	end

	assign sda_out = 1'b0;

	// ****************************************
	// Crossing into the system clock
	// ****************************************
	logic [1:0] link_s;
	logic       busy_s, wr_tgl_s, wr_seen_ff, wr_stb;

	pin_sync #(.WIDTH(2)) u_link_sync (
		.clk    (clk),
		.resetn (resetn),
		.d      ({open_tgl_ff ^ stop_tgl_ff, wr_tgl_ff}),
		.q      (link_s)
	);

	assign {busy_s, wr_tgl_s} = link_s;
	assign wr_stb             = wr_tgl_s ^ wr_seen_ff;

	// Write toggle edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_seen_ff <= 1'b0;
		end else begin
			wr_seen_ff <= wr_tgl_s;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	logic [7:0] ctrl_ff;
	logic [5:0] heat_code_ff;
	logic [5:0] cool_code_ff;
	logic       release_stb;

	// Keep limit codes inside the legal span
	function automatic logic [5:0] clamp_code(input logic [5:0] c);
		return (c > tec_seq_pkg::VOLTAGE_LIMIT_FLAG_CODE_MAX) ? tec_seq_pkg::VOLTAGE_LIMIT_FLAG_CODE_MAX : c;
	endfunction : clamp_code

	assign release_stb = wr_stb && (wr_addr_ff == tec_seq_pkg::REG_CTRL) && wr_data_ff[tec_seq_pkg::CTRL_REL_BIT];

	// Register writes; release bit never stored
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_ff      <= tec_seq_pkg::CTRL_RESET;
			heat_code_ff <= tec_seq_pkg::VOLTAGE_LIMIT_FLAG_CODE_RESET;
			cool_code_ff <= tec_seq_pkg::VOLTAGE_LIMIT_FLAG_CODE_RESET;
		end else if (wr_stb) begin
			unique case (wr_addr_ff)
				tec_seq_pkg::REG_CTRL:      ctrl_ff <= wr_data_ff & ~(8'h01 << tec_seq_pkg::CTRL_REL_BIT);
				tec_seq_pkg::REG_HEAT_VOLTAGE_LIMIT_FLAG: heat_code_ff <= clamp_code(wr_data_ff[5:0]);
				tec_seq_pkg::REG_COOL_VOLTAGE_LIMIT_FLAG: cool_code_ff <= clamp_code(wr_data_ff[5:0]);
				default:                    ctrl_ff <= ctrl_ff;
			endcase
		end
	end

	assign monitor_select          = ctrl_ff[tec_seq_pkg::CTRL_MON_BIT];
	assign heat_voltage_limit_code = heat_code_ff;
	assign cool_voltage_limit_code = cool_code_ff;

	// ****************************************
	// Address strap and status flags
	// ****************************************
	logic [1:0] strap_cnt_ff;
	logic [6:0] addr_ff;
	logic [3:0] flags_ff;
	logic [1:0] dir;
	logic [7:0] status;

	// Catch strap once synchroniser has filled
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			strap_cnt_ff <= 2'h0;
			addr_ff      <= tec_seq_pkg::ADDR_STRAP_HIGH;
		end else if (strap_cnt_ff != 2'h3) begin
			strap_cnt_ff <= strap_cnt_ff + 2'h1;
			if (strap_cnt_ff == 2'h2) begin
				addr_ff <= strap_s ? tec_seq_pkg::ADDR_STRAP_HIGH : tec_seq_pkg::ADDR_STRAP_LOW;
			end
		end
	end

	// Sticky flags: set wins over release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flags_ff <= 4'h0;
		end else begin
			flags_ff <= (flags_ff & {4{~release_stb}}) | {voltage_limit_flag_s, current_limit_flag_s, ot_s, otw_s};
		end
	end

	// Direction never reports the reserved code
	assign dir = (heat_s && !cool_s) ? tec_seq_pkg::DIR_HEAT :
	             (cool_s && !heat_s) ? tec_seq_pkg::DIR_COOL : tec_seq_pkg::DIR_BOUNDARY;

	assign status = {dir, flags_ff[3], flags_ff[2], power_stage_active, 1'b0, flags_ff[1], flags_ff[0]};

	// Snapshot frozen while a frame is on the bus
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			snap_addr_ff   <= tec_seq_pkg::ADDR_STRAP_HIGH;
			snap_ctrl_ff   <= tec_seq_pkg::CTRL_RESET;
			snap_status_ff <= 8'h00;
			snap_heat_ff   <= tec_seq_pkg::VOLTAGE_LIMIT_FLAG_CODE_RESET;
			snap_cool_ff   <= tec_seq_pkg::VOLTAGE_LIMIT_FLAG_CODE_RESET;
		end else if (!busy_s) begin
			snap_addr_ff   <= addr_ff;
			snap_ctrl_ff   <= ctrl_ff;
			snap_status_ff <= status;
			snap_heat_ff   <= heat_code_ff;
			snap_cool_ff   <= cool_code_ff;
		end
	end

	// ****************************************
	// Shutdown pin delay
	// ****************************************
	logic [tec_seq_pkg::TMR_W-1:0] sd_cnt_ff;
	logic                          sd_ready;

	assign sd_ready = (sd_cnt_ff == tec_seq_pkg::TMR_W'(SD_DELAY_CYC));

	// Count high time, restart when low
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sd_cnt_ff <= '0;
		end else if (!sdn_s) begin
			sd_cnt_ff <= '0;
		end else if (!sd_ready) begin
			sd_cnt_ff <= sd_cnt_ff + 1'b1;
		end
	end

	// ****************************************
	// Soft-start and hiccup sequencer
	// ****************************************
	tec_seq_pkg::seq_state_t state_ff, nxt_state;
	logic [tec_seq_pkg::TMR_W-1:0] tmr_ff, nxt_tmr, split_cyc;
	logic run_ok, legs_on;

	assign run_ok    = supply_s && enable_s && sd_ready && ctrl_ff[tec_seq_pkg::CTRL_EN_BIT] && !ot_s;
	assign split_cyc = tec_seq_pkg::TMR_W'(SS_SPLIT_CYC >> ctrl_ff[tec_seq_pkg::CTRL_SS_LSB +: 2]);
	assign legs_on   = (state_ff == tec_seq_pkg::SEQ_RAMP_JNT) || (state_ff == tec_seq_pkg::SEQ_RAMP_SPL) ||
	                   (state_ff == tec_seq_pkg::SEQ_RUN);

	// Next state and step timer
	always_comb begin
		nxt_state = state_ff;
		nxt_tmr   = tmr_ff + 1'b1;
		if (!run_ok) begin
			nxt_state = tec_seq_pkg::SEQ_OFF;
		end else begin
			unique case (state_ff)
				tec_seq_pkg::SEQ_OFF: nxt_state = tec_seq_pkg::SEQ_DISCHARGE;
				tec_seq_pkg::SEQ_DISCHARGE: begin
					if (tmr_ff == tec_seq_pkg::TMR_W'(DISCHARGE_CYC - 1)) begin
						nxt_tmr = '0;
						if (low_s) begin
							nxt_state = tec_seq_pkg::SEQ_RAMP_JNT;
						end
					end
				end
				tec_seq_pkg::SEQ_RAMP_JNT: begin
					if (mid_s) begin
						nxt_state = tec_seq_pkg::SEQ_RAMP_SPL;
					end
				end
				tec_seq_pkg::SEQ_RAMP_SPL: begin
					if (tmr_ff >= split_cyc - 1'b1) begin
						nxt_state = tec_seq_pkg::SEQ_RUN;
					end
				end
				tec_seq_pkg::SEQ_RUN: nxt_state = tec_seq_pkg::SEQ_RUN;
				tec_seq_pkg::SEQ_HIC_OFF: begin
					if (tmr_ff == tec_seq_pkg::TMR_W'(HICCUP_OFF_CYC - 1)) begin
						nxt_tmr = '0;
						if (low_s) begin
							nxt_state = tec_seq_pkg::SEQ_HIC_DET;
						end
					end
				end
				tec_seq_pkg::SEQ_HIC_DET: begin
					if (fault_s) begin
						nxt_state = tec_seq_pkg::SEQ_HIC_OFF;
					end else if (tmr_ff == tec_seq_pkg::TMR_W'(DETECT_CYC - 1)) begin
						nxt_state = tec_seq_pkg::SEQ_DISCHARGE;
					end
				end
				default: nxt_state = tec_seq_pkg::SEQ_OFF;
			endcase
			if (legs_on && (sov_s || fault_s)) begin
				nxt_state = tec_seq_pkg::SEQ_HIC_OFF;
			end
		end
		if (nxt_state != state_ff) begin
			nxt_tmr = '0;
		end
	end

	// State, timer and registered stage controls
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff           <= tec_seq_pkg::SEQ_OFF;
			tmr_ff             <= '0;
			legs_enable        <= 1'b0;
			discharge_step     <= 1'b0;
			joint_ramp         <= 1'b0;
			split_ramp         <= 1'b0;
			detect_regulate    <= 1'b0;
			power_stage_active <= 1'b0;
			regulate_at_limit  <= 1'b0;
		end else begin
			state_ff           <= nxt_state;
			tmr_ff             <= nxt_tmr;
			legs_enable        <= (nxt_state == tec_seq_pkg::SEQ_RAMP_JNT) || (nxt_state == tec_seq_pkg::SEQ_RAMP_SPL) ||
			                      (nxt_state == tec_seq_pkg::SEQ_RUN) || (nxt_state == tec_seq_pkg::SEQ_HIC_DET);
			discharge_step     <= (nxt_state == tec_seq_pkg::SEQ_DISCHARGE);
			joint_ramp         <= (nxt_state == tec_seq_pkg::SEQ_RAMP_JNT);
			split_ramp         <= (nxt_state == tec_seq_pkg::SEQ_RAMP_SPL);
			detect_regulate    <= (nxt_state == tec_seq_pkg::SEQ_HIC_DET);
			power_stage_active <= (nxt_state == tec_seq_pkg::SEQ_RAMP_SPL) || (nxt_state == tec_seq_pkg::SEQ_RUN);
			regulate_at_limit  <= voltage_limit_flag_s && ((nxt_state == tec_seq_pkg::SEQ_RAMP_SPL) ||
			                      (nxt_state == tec_seq_pkg::SEQ_RUN));
		end
	end

endmodule : tec_seq_status

/* File: verif/tec_seq_status_props.sv */
`timescale 1ns/10ps
// ****************************************
// Sequencer port checks
// ****************************************
module tec_seq_status_props (
	input wire logic clk,
	input wire logic resetn,
	input wire logic supply_ok,
	input wire logic enable_pin,
	input wire logic shutdown_n_pin,
	input wire logic secondary_ov,
	input wire logic legs_enable,
	input wire logic discharge_step,
	input wire logic joint_ramp,
	input wire logic split_ramp,
	input wire logic detect_regulate,
	input wire logic power_stage_active
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// Gating, ordering and fault reaction
	a_pin_off_gate: assert property (!shutdown_n_pin [*5] |-> !legs_enable && !power_stage_active)
		else $error("stage on while shutdown low");
	a_turn_on_wait: assert property ($rose(shutdown_n_pin) |-> !legs_enable [*8])
		else $error("stage on too soon");
	a_supply_gate: assert property (!(supply_ok && enable_pin) [*5] |-> !legs_enable && !discharge_step)
		else $error("stage on without supply or enable");
	a_joint_after_dis: assert property ($rose(joint_ramp) |-> $past(discharge_step))
		else $error("joint ramp not after discharge");
	a_split_after_joint: assert property ($rose(split_ramp) |-> $past(joint_ramp))
		else $error("split ramp not after joint ramp");
	a_active_late: assert property (power_stage_active |-> !discharge_step && !joint_ramp)
		else $error("active flag during early steps");
	a_ov_hiccup: assert property (power_stage_active && secondary_ov |-> ##[1:6] !legs_enable)
		else $error("switching kept after over-voltage");
	a_detect_from_off: assert property ($rose(detect_regulate) |-> !$past(legs_enable))
		else $error("detect window not after off time");
endmodule : tec_seq_status_props

bind tec_seq_status tec_seq_status_props tec_seq_status_props_inst (
	.clk, .resetn, .supply_ok, .enable_pin, .shutdown_n_pin, .secondary_ov, .legs_enable,
	.discharge_step, .joint_ramp, .split_ramp, .detect_regulate, .power_stage_active
);

/* File: verif/i2c_host_model.sv */
`timescale 1ns/10ps
// ****************************************
// Bus host on the register link
// ****************************************
module i2c_host_model (
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	logic [7:0] rx_byte;
	event       got;
	// Clock parked high between frames
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Nine bits, data moved only while clock low
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sda_low = !tx[i];
			#8 scl = 1'b1;
			#16 rx[i] = sda;
			scl = 1'b0;
			#8;
		end
	endtask : xfer
	task automatic start;
		sda_low = 1'b0;
		#8 scl = 1'b1;
		#16 sda_low = 1'b1;
		#16 scl = 1'b0;
		#8;
	endtask : start
	task automatic stop;
		sda_low = 1'b1;
		#8 scl = 1'b1;
		#16 sda_low = 1'b0;
		#16;
	endtask : stop
	// Address, pointer, one data byte
	task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] dat, output logic ack);
		logic [8:0] r1, r2, r3;
		start();
		xfer({dev, 2'h1}, r1);
		xfer({ptr, 1'b1}, r2);
		xfer({dat, 1'b1}, r3);
		stop();
		ack = !(r1[0] | r2[0] | r3[0]);
	endtask : wr
	// Pointer set, repeated start, one byte then no-ack
	task automatic rd(input logic [6:0] dev, input logic [7:0] ptr);
		logic [8:0] r;
		start();
		xfer({dev, 2'h1}, r);
		xfer({ptr, 1'b1}, r);
		start();
		xfer({dev, 2'h3}, r);
		xfer(9'h1FF, r);
		stop();
		rx_byte = r[8:1];
		->got;
	endtask : rd
endmodule : i2c_host_model

/* File: verif/tb.sv */
`timescale 1ns/10ps
// ****************************************
// Bench for sequencer and status block
// ****************************************
module tb;
	logic       clk, resetn, scl, sda_low, sda_in, sda_out, sda_oe, ack, regulate_at_limit, monitor_select;
	logic       supply_ok, enable_pin, shutdown_n_pin, addr_strap, outputs_low, mid_level_reached, voltage_limit_flag_reached;
	logic       current_limit_flag_reached, overtemp_in, overtemp_warn_in, secondary_ov, hard_fault, heating_det, cooling_det;
	logic       legs_enable, discharge_step, joint_ramp, split_ramp, detect_regulate, power_stage_active;
	logic [5:0] heat_voltage_limit_code, cool_voltage_limit_code;
	logic [7:0] exp_q[$], m;
	int         err_count, checked, n;
	assign sda_in = !(sda_low | sda_oe); // Pull-up
	tec_seq_status #(.SD_DELAY_CYC(40), .HICCUP_OFF_CYC(30), .DETECT_CYC(10), .DISCHARGE_CYC(8), .SS_SPLIT_CYC(64))
	tec_seq_status_inst (.clk, .resetn, .scl, .sda_in, .sda_out, .sda_oe, .supply_ok, .enable_pin, .shutdown_n_pin,
		.addr_strap, .outputs_low, .mid_level_reached, .voltage_limit_flag_reached, .current_limit_flag_reached, .overtemp_in, .overtemp_warn_in,
		.secondary_ov, .hard_fault, .heating_det, .cooling_det, .legs_enable, .discharge_step, .joint_ramp,
		.split_ramp, .detect_regulate, .regulate_at_limit, .power_stage_active, .monitor_select,
		.heat_voltage_limit_code, .cool_voltage_limit_code);
	i2c_host_model i2c_host_model_inst (.scl, .sda_low, .sda(sda_in));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
		exp_q.push_back(exp);
		i2c_host_model_inst.rd(7'h60, ptr);
	endtask : rd
	task automatic wr(input logic [7:0] ptr, input logic [7:0] dat);
		i2c_host_model_inst.wr(7'h60, ptr, dat, ack);
		chk(ack, 8'h01);
		repeat (5) @(negedge clk);
	endtask : wr
	// Each read byte against the oldest note
	always @(i2c_host_model_inst.got) chk(i2c_host_model_inst.rx_byte, exp_q.pop_front());
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Watchdog, several times the expected run
	initial begin
		#200us;
		err_count++;
		report_and_stop();
	end
	// Test sequence
	initial begin
		{supply_ok, enable_pin, shutdown_n_pin, addr_strap, outputs_low, mid_level_reached, voltage_limit_flag_reached, current_limit_flag_reached,
			overtemp_in, overtemp_warn_in, secondary_ov, hard_fault, heating_det, cooling_det} = 14'h2400;
		resetn = 1'b0;
		m = $urandom(32'h9B54);
		repeat (3) @(posedge clk);
		@(negedge clk) resetn = 1'b1;
		repeat (10) @(negedge clk);
		rd(8'h06, 8'hC0);
		rd(8'h0A, {tec_seq_pkg::MAKER_CODE, tec_seq_pkg::REVISION_CODE});
		rd(8'h00, 8'h81);
		chk(monitor_select, 8'h01);
		rd(8'h07, 8'h00);
		i2c_host_model_inst.wr(7'h21, 8'h00, 8'h00, ack);
		chk(ack, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			{heating_det, cooling_det} = i[1:0];
			repeat (4) @(negedge clk);
			rd(8'h09, {(i == 3) ? 2'h0 : i[1:0], 6'h00});
		end
		$display("test direction done");
		m = 8'($urandom()) & 8'h33;
		{voltage_limit_flag_reached, current_limit_flag_reached, overtemp_in, overtemp_warn_in} = {m[5], m[4], m[1], m[0]};
		repeat (5) @(negedge clk);
		{voltage_limit_flag_reached, current_limit_flag_reached, overtemp_in, overtemp_warn_in} = 4'h0;
		rd(8'h09, m);
		wr(8'h00, 8'h83);
		rd(8'h00, 8'h81);
		rd(8'h09, 8'h00);
		$display("test flags done");
		m = 8'($urandom_range(55));
		wr(8'h00, 8'h0D);
		wr(8'h03, 8'h3F);
		wr(8'h04, m);
		chk(monitor_select, 8'h00);
		chk(heat_voltage_limit_code, 8'h37);
		chk(cool_voltage_limit_code, m);
		{enable_pin, shutdown_n_pin} = 2'h3;
		for (n = 0; discharge_step !== 1'b1 && n < 200; n++) @(negedge clk);
		chk(n >= 40, 8'h01);
		repeat (24) @(negedge clk);
		chk({discharge_step, joint_ramp}, 8'h02);
		outputs_low = 1'b1;
		for (n = 0; joint_ramp !== 1'b1 && n < 40; n++) @(negedge clk);
		chk(legs_enable, 8'h01);
		mid_level_reached = 1'b1;
		for (n = 0; split_ramp !== 1'b1 && n < 40; n++) @(negedge clk);
		for (n = 0; split_ramp === 1'b1 && n < 100; n++) @(negedge clk);
		chk(n inside {[7:9]}, 8'h01);
		chk(power_stage_active, 8'h01);
		rd(8'h09, 8'h08);
		chk(regulate_at_limit, 8'h00);
		voltage_limit_flag_reached = 1'b1;
		repeat (4) @(negedge clk);
		chk(regulate_at_limit, 8'h01);
		voltage_limit_flag_reached = 1'b0;
		$display("test soft start done");
		outputs_low = 1'b0;
		secondary_ov = 1'b1;
		repeat (4) @(negedge clk);
		secondary_ov = 1'b0;
		chk(legs_enable, 8'h00);
		repeat (70) @(negedge clk);
		chk(detect_regulate, 8'h00);
		outputs_low = 1'b1;
		for (n = 0; detect_regulate !== 1'b1 && n < 40; n++) @(negedge clk);
		for (n = 0; discharge_step !== 1'b1 && n < 40; n++) @(negedge clk);
		chk(n inside {[8:13]}, 8'h01);
		$display("test hiccup done");
		repeat (40) @(negedge clk);
		wr(8'h00, 8'h0C);
		chk(legs_enable, 8'h00);
		shutdown_n_pin = 1'b0;
		repeat (6) @(negedge clk);
		chk({legs_enable, power_stage_active}, 8'h00);
		$display("test disable done");
		report_and_stop();
	end
endmodule : tb
